// ---- core/icc_channel.sv ----
/*
 * Input capture channel: edge detection on the capture pin, prescaler,
 * time base selection, four-entry capture FIFO, sticky status with mask,
 * level interrupt and wake-up request, all behind a Wishbone slave.
 * Assumes both time base counts are synchronous to clk_i (an externally
 * clocked timer resynchronises its own count) and low_power_i is on clk_i.
 */
// The address map and register access over Wishbone were chosen for this implementation.
module icc_channel
	import icc_pkg::*;
#(
	parameter int DEPTH = ICC_FIFO_DEPTH
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire icc_wb_req_s  wb_req_i,
	output logic [31:0]       wb_dat_o,
	output logic              wb_ack_o,
	input  wire logic         capture_input_pin_i,
	input  wire logic [15:0]  first_time_base_i,
	input  wire logic [15:0]  second_time_base_i,
	input  wire logic         low_power_i,
	output logic              irq_o,
	output logic              wake_o
);

	localparam int PW = $clog2(DEPTH);

	// ****************************************
	// Registers and state
	// ****************************************
	icc_ctrl_s          ctrl_reg;
	logic [2:0]         stat_reg;
	logic [2:0]         mask_reg;
	logic               pin_meta_reg;
	logic               pin_sync_reg;
	logic               pin_prev_reg;
	logic               armed_reg;
	logic [3:0]         pre_cnt_reg;
	logic [31:0]        fifo_reg [DEPTH];
	logic [PW-1:0]      wr_ptr_reg;
	logic [PW-1:0]      rd_ptr_reg;
	logic [PW:0]        count_reg;
	logic               ack_reg;
	logic [31:0]        rdata_reg;
	logic               irq_reg;
	logic               wake_reg;

	logic               rise;
	logic               fall;
	logic               cap_ev;
	logic               push;
	logic               pop;
	logic               full;
	logic [31:0]        snap;
	logic [31:0]        bmask;
	logic               bus_req;
	logic               wr_hit;
	logic [2:0]         stat_set;

	assign bus_req = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
	assign wr_hit  = bus_req && wb_req_i.we;
	assign bmask   = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

	// ****************************************
	// Pin synchroniser and edge detection
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg <= capture_input_pin_i;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	assign rise = pin_sync_reg && !pin_prev_reg;
	assign fall = !pin_sync_reg && pin_prev_reg;

	// ****************************************
	// Capture event selection
	// ****************************************
	always_comb begin
		cap_ev = 1'b0;
		if (ctrl_reg.enable) begin
			unique case (ctrl_reg.mode)
				ICC_FALL:       cap_ev = fall;
				ICC_RISE:       cap_ev = rise;
				ICC_EDGE:       cap_ev = rise || fall;
				ICC_EDGE_FIRST: cap_ev = armed_reg ? (rise || fall)
				                         : (ctrl_reg.first_rise ? rise : fall);
				ICC_DIV4:       cap_ev = rise && (pre_cnt_reg[1:0] == ICC_DIV4_LAST);
				ICC_DIV16:      cap_ev = rise && (pre_cnt_reg == ICC_DIV16_LAST);
				default:        cap_ev = 1'b0;
			endcase
		end
	end

	// Arming and prescaler restart whenever the channel is disabled
	// The prescaler counts in every mode; disable before entering a divide mode
	always_ff @(posedge clk_i) begin
		if (rst_i || !ctrl_reg.enable) begin
			armed_reg   <= 1'b0;
			pre_cnt_reg <= 4'h0;
		end else begin
			if (cap_ev && ctrl_reg.mode == ICC_EDGE_FIRST)
				armed_reg <= 1'b1;
			if (rise)
				pre_cnt_reg <= pre_cnt_reg + 4'h1;
		end
	end

	// ****************************************
	// Time base snapshot and FIFO
	// ****************************************
	// Counts are sampled on clk_i whatever clocks the timers
	always_comb begin
		if (ctrl_reg.wide)
			snap = {second_time_base_i, first_time_base_i};
		else if (ctrl_reg.sel_second)
			snap = {16'h0000, second_time_base_i};
		else
			snap = {16'h0000, first_time_base_i};
	end

	// A capture into a full FIFO is dropped; the oldest entries are kept
	assign full = (count_reg == (PW+1)'(DEPTH));
	assign push = cap_ev && !full;
	assign pop  = bus_req && !wb_req_i.we && wb_req_i.adr == ICC_OFS_DATA && count_reg != '0;

	always_ff @(posedge clk_i) begin
		if (push)
			fifo_reg[wr_ptr_reg] <= snap;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + PW'(1);
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + PW'(1);
			if (push && !pop)
				count_reg <= count_reg + (PW+1)'(1);
			else if (pop && !push)
				count_reg <= count_reg - (PW+1)'(1);
		end
	end

	// ****************************************
	// Status, interrupt and wake-up
	// ****************************************
	always_comb begin
		stat_set = 3'h0;
		stat_set[ICC_ST_THRESH] = push && (count_reg == {1'b0, ctrl_reg.level});
		stat_set[ICC_ST_OVF]    = cap_ev && full;
		stat_set[ICC_ST_PIN]    = cap_ev;
	end

	// Hardware set wins over a same-cycle write-one-to-clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			stat_reg <= ICC_STAT_RST;
		else if (wr_hit && wb_req_i.adr == ICC_OFS_STAT)
			stat_reg <= (stat_reg & ~(wb_req_i.dat[2:0] & bmask[2:0])) | stat_set;
		else
			stat_reg <= stat_reg | stat_set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg  <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			irq_reg  <= |(stat_reg & mask_reg);
			wake_reg <= low_power_i && cap_ev;
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= icc_ctrl_s'(ICC_CTRL_RST);
			mask_reg <= ICC_MASK_RST;
		end else if (wr_hit) begin
			if (wb_req_i.adr == ICC_OFS_CTRL)
				ctrl_reg <= icc_ctrl_s'((ctrl_reg & ~bmask[8:0]) | (wb_req_i.dat[8:0] & bmask[8:0]));
			if (wb_req_i.adr == ICC_OFS_MASK)
				mask_reg <= (mask_reg & ~bmask[2:0]) | (wb_req_i.dat[2:0] & bmask[2:0]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg   <= bus_req;
			rdata_reg <= 32'h0000_0000;
			if (bus_req && !wb_req_i.we) begin
				unique case (wb_req_i.adr)
					ICC_OFS_CTRL:  rdata_reg <= {23'h000000, ctrl_reg};
					ICC_OFS_STAT:  rdata_reg <= {29'h00000000, stat_reg};
					ICC_OFS_MASK:  rdata_reg <= {29'h00000000, mask_reg};
					ICC_OFS_DATA:  rdata_reg <= (count_reg != '0) ? fifo_reg[rd_ptr_reg] : 32'h0000_0000;
					ICC_OFS_LEVEL: rdata_reg <= 32'(count_reg);
					default:       rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
	assign irq_o    = irq_reg;
	assign wake_o   = wake_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_fall_capture: assert property (ctrl_reg.enable && ctrl_reg.mode == ICC_FALL && $fell(pin_sync_reg)
		|-> cap_ev) else $error("falling edge not captured");
	a_rise_capture: assert property (ctrl_reg.enable && ctrl_reg.mode == ICC_RISE
		|-> cap_ev == $rose(pin_sync_reg)) else $error("rising capture mismatch");
	a_every_edge: assert property (ctrl_reg.enable && ctrl_reg.mode == ICC_EDGE
		|-> cap_ev == (pin_sync_reg != $past(pin_sync_reg))) else $error("edge capture mismatch");
	a_first_edge: assert property (ctrl_reg.enable && ctrl_reg.mode == ICC_EDGE_FIRST && !armed_reg
		&& ctrl_reg.first_rise && fall |-> !cap_ev) else $error("captured before first edge");
	a_first_arm: assert property (ctrl_reg.enable && ctrl_reg.mode == ICC_EDGE_FIRST && cap_ev
		|=> armed_reg) else $error("first edge did not arm");
	a_div4_count: assert property (ctrl_reg.enable && ctrl_reg.mode == ICC_DIV4 && cap_ev
		|-> rise && pre_cnt_reg[1:0] == 2'h3) else $error("div4 capture off count");
	a_div16_count: assert property (ctrl_reg.enable && ctrl_reg.mode == ICC_DIV16 && cap_ev
		|-> rise && pre_cnt_reg == 4'hf) else $error("div16 capture off count");
	a_pre_advance: assert property (ctrl_reg.enable && rise
		|=> pre_cnt_reg == $past(pre_cnt_reg) + 4'h1) else $error("prescaler missed a rising edge");
	a_snap_wide: assert property (push && ctrl_reg.wide
		|=> fifo_reg[$past(wr_ptr_reg)] == {$past(second_time_base_i), $past(first_time_base_i)})
		else $error("32-bit snapshot wrong");
	a_snap_narrow: assert property (push && !ctrl_reg.wide
		|=> fifo_reg[$past(wr_ptr_reg)] == {16'h0000, $past(ctrl_reg.sel_second)
		? $past(second_time_base_i) : $past(first_time_base_i)}) else $error("16-bit snapshot wrong");
	a_sync_delay: assert property ($rose(capture_input_pin_i) ##1 capture_input_pin_i ##1 capture_input_pin_i
		|-> pin_sync_reg) else $error("pin not synchronised in two cycles");
	a_wake_event: assert property (cap_ev && low_power_i |=> wake_o) else $error("no wake request");
	a_wake_cause: assert property (wake_o
		|-> $past(cap_ev) && $past(low_power_i)) else $error("spurious wake request");
	a_fifo_count: assert property (push && !pop
		|=> count_reg == $past(count_reg) + 3'h1) else $error("fifo count not advanced");
	a_fifo_pop: assert property (pop && !push
		|=> count_reg == $past(count_reg) - 3'h1) else $error("fifo count not reduced");
	a_read_data: assert property (pop
		|=> wb_dat_o == $past(fifo_reg[rd_ptr_reg])) else $error("read data not oldest entry");
	a_level_flag: assert property (push && count_reg == {1'b0, ctrl_reg.level}
		|=> stat_reg[ICC_ST_THRESH] ##1 (irq_o || !$past(mask_reg[ICC_ST_THRESH])))
		else $error("threshold flag or interrupt missing");
	a_pin_flag: assert property (cap_ev |=> stat_reg[ICC_ST_PIN]) else $error("pin flag not set");
	a_pin_sticky: assert property (stat_reg[ICC_ST_PIN] && !(wr_hit && wb_req_i.adr == ICC_OFS_STAT
		&& wb_req_i.dat[ICC_ST_PIN] && wb_req_i.sel[0]) |=> stat_reg[ICC_ST_PIN]) else $error("pin flag lost");
	a_irq_level: assert property (|(stat_reg & mask_reg) |=> irq_o) else $error("interrupt not raised");
	a_irq_clear: assert property ((stat_reg & mask_reg) == 3'h0 |=> !irq_o) else $error("interrupt stuck");
	a_disabled_quiet: assert property (!ctrl_reg.enable |-> !cap_ev) else $error("capture while disabled");
	a_overflow_drop: assert property (cap_ev && full
		|-> !push ##1 stat_reg[ICC_ST_OVF] && count_reg == ($past(pop) ? 3'h3 : 3'h4))
		else $error("overflow not handled");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");

	c_fill_fifo:  cover property (count_reg == 3'h4);
	c_overflow:   cover property (cap_ev && full);
	c_div16_hit:  cover property (ctrl_reg.mode == ICC_DIV16 && push);
	c_read_pop:   cover property (pop ##2 pop);
	c_edge_first: cover property (ctrl_reg.mode == ICC_EDGE_FIRST && armed_reg && push);

endmodule // icc_channel

// ---- core/icc_pkg.sv ----
/*
 * Shared constants and types for the input capture channel: register
 * offsets, field layouts, reset values, capture modes and bus carriers.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package icc_pkg;

	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam int          ICC_ADR_W      = 5;
	localparam logic [4:0]  ICC_OFS_CTRL   = 5'h00;
	localparam logic [4:0]  ICC_OFS_STAT   = 5'h04;
	localparam logic [4:0]  ICC_OFS_MASK   = 5'h08;
	localparam logic [4:0]  ICC_OFS_DATA   = 5'h0c;
	localparam logic [4:0]  ICC_OFS_LEVEL  = 5'h10;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int          ICC_CTRL_W     = 9;
	localparam logic [8:0]  ICC_CTRL_RST   = 9'h000;
	localparam int          ICC_STAT_W     = 3;
	localparam int          ICC_ST_THRESH  = 0;
	localparam int          ICC_ST_OVF     = 1;
	localparam int          ICC_ST_PIN     = 2;
	localparam logic [2:0]  ICC_STAT_RST   = 3'h0;
	localparam logic [2:0]  ICC_MASK_RST   = 3'h0;
	localparam int          ICC_FIFO_DEPTH = 4;
	localparam logic [1:0]  ICC_DIV4_LAST  = 2'h3;
	localparam logic [3:0]  ICC_DIV16_LAST = 4'hf;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ICC_FALL,
		ICC_RISE,
		ICC_EDGE,
		ICC_EDGE_FIRST,
		ICC_DIV4,
		ICC_DIV16
	} icc_mode_e;

	// Bit 0 enable, 3:1 mode, 4 first edge rising, 5 32-bit, 6 second base, 8:7 level
	typedef struct packed {
		logic [1:0] level;
		logic       sel_second;
		logic       wide;
		logic       first_rise;
		icc_mode_e  mode;
		logic       enable;
	} icc_ctrl_s;

	typedef struct packed {
		logic                 cyc;
		logic                 stb;
		logic                 we;
		logic [ICC_ADR_W-1:0] adr;
		logic [3:0]           sel;
		logic [31:0]          dat;
	} icc_wb_req_s;

endpackage : icc_pkg

// ---- test/icc_pin_src.sv ----
/*
 * Signal source driving the capture input pin of the channel.
 * Assumes the bench calls pulse() from a process synchronous to clk_i.
 */
module icc_pin_src (
	input  wire logic clk_i,
	output logic      pin_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial pin_o = 1'b0;

	// High phase of three cycles and low phase of at least six, wider than the synchroniser needs
	task automatic pulse();
		repeat (2) @(posedge clk_i);
		pin_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		pin_o <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
endmodule // icc_pin_src

// ---- test/tb_input_capture_channel.sv ----
/*
 * Self-checking bench for the input capture channel.
 * Assumes icc_pkg and icc_channel are compiled first; registers reached
 * over classic Wishbone, pin driven by icc_pin_src.
 */
module tb_input_capture_channel;
	import icc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Signals and instances
	// ****************************************
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	icc_wb_req_s req   = '0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        pin;
	logic [15:0] tb1   = 16'h0;
	logic [15:0] tb2   = 16'h0;
	logic        lp    = 1'b0;
	logic        irq_o;
	logic        wake_o;
	logic [31:0] q;
	int          fails = 0;
	int          n_tests = 0;
	int          cyc_n = 0;
	int          wakes = 0;

	icc_channel uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .capture_input_pin_i(pin), .first_time_base_i(tb1),
		.second_time_base_i(tb2), .low_power_i(lp), .irq_o(irq_o), .wake_o(wake_o)
	);
	icc_pin_src src (.clk_i(clk_i), .pin_o(pin));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc_n++;
		if (wake_o === 1'b1)
			wakes++;
		if (cyc_n == 20000) begin
			fails++;
			tally_and_finish();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic tally_and_finish();
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		req <= '0;
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	// Disabling first clears prescaler count and first-edge arming
	task automatic setc(input icc_mode_e m, input logic [1:0] lv, input logic s2, input logic w, input logic fr);
		icc_ctrl_s c;
		c = '{lv, s2, w, fr, m, 1'b1};
		wb(1'b1, ICC_OFS_CTRL, 32'h0);
		wb(1'b1, ICC_OFS_STAT, 32'h7);
		wb(1'b1, ICC_OFS_CTRL, 32'(c));
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rdchk(ICC_OFS_CTRL, 32'h0);
		rdchk(ICC_OFS_STAT, 32'h0);
		rdchk(ICC_OFS_MASK, 32'h0);
		rdchk(ICC_OFS_LEVEL, 32'h0);
		rdchk(ICC_OFS_DATA, 32'h0);
		wb(1'b1, 5'h14, 32'hffffffff);
		rdchk(5'h14, 32'h0);
	endtask

	task automatic t_modes();
		for (int i = 0; i < 3; i++) begin
			setc(icc_mode_e'(i), 2'h0, 1'b0, 1'b0, 1'b0);
			tb1 <= 16'h1100 + 16'(i);
			src.pulse();
			rdchk(ICC_OFS_LEVEL, (i == 2) ? 32'h2 : 32'h1);
			for (int j = 0; j < ((i == 2) ? 2 : 1); j++)
				rdchk(ICC_OFS_DATA, 32'h1100 + 32'(i));
		end
		setc(ICC_EDGE_FIRST, 2'h0, 1'b0, 1'b0, 1'b0);
		src.pulse();
		src.pulse();
		rdchk(ICC_OFS_LEVEL, 32'h3);
		repeat (3) wb(1'b0, ICC_OFS_DATA, 32'h0);
		setc(ICC_EDGE_FIRST, 2'h0, 1'b0, 1'b0, 1'b1);
		src.pulse();
		rdchk(ICC_OFS_LEVEL, 32'h2);
		repeat (2) wb(1'b0, ICC_OFS_DATA, 32'h0);
	endtask

	task automatic t_div(input icc_mode_e m, input int n);
		setc(m, 2'h0, 1'b0, 1'b0, 1'b0);
		repeat (n - 1) src.pulse();
		rdchk(ICC_OFS_LEVEL, 32'h0);
		src.pulse();
		rdchk(ICC_OFS_LEVEL, 32'h1);
		wb(1'b0, ICC_OFS_DATA, 32'h0);
	endtask

	task automatic t_width();
		tb1 <= 16'h1234;
		tb2 <= 16'habcd;
		setc(ICC_RISE, 2'h0, 1'b0, 1'b1, 1'b0);
		src.pulse();
		rdchk(ICC_OFS_DATA, 32'habcd1234);
		setc(ICC_RISE, 2'h0, 1'b1, 1'b0, 1'b0);
		src.pulse();
		rdchk(ICC_OFS_DATA, 32'h0000abcd);
	endtask

	task automatic t_fifo();
		setc(ICC_RISE, 2'h0, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			tb1 <= 16'(i + 1);
			src.pulse();
		end
		rdchk(ICC_OFS_LEVEL, 32'h4);
		rdchk(ICC_OFS_STAT, 32'h7);
		for (int i = 0; i < 4; i++)
			rdchk(ICC_OFS_DATA, 32'(i + 1));
		rdchk(ICC_OFS_DATA, 32'h0);
		wb(1'b1, ICC_OFS_STAT, 32'h2);
		rdchk(ICC_OFS_STAT, 32'h5);
	endtask

	task automatic t_irq();
		setc(ICC_RISE, 2'h1, 1'b0, 1'b0, 1'b0);
		wb(1'b1, ICC_OFS_MASK, 32'h1);
		src.pulse();
		chk(irq_o, 1'b0);
		src.pulse();
		chk(irq_o, 1'b1);
		wb(1'b1, ICC_OFS_MASK, 32'h4);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b1);
		wb(1'b1, ICC_OFS_STAT, 32'h7);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0);
		wb(1'b1, ICC_OFS_MASK, 32'h0);
		repeat (2) wb(1'b0, ICC_OFS_DATA, 32'h0);
	endtask

	task automatic t_wake();
		setc(ICC_RISE, 2'h0, 1'b0, 1'b0, 1'b0);
		lp <= 1'b1;
		src.pulse();
		chk(wakes, 32'h1);
		lp <= 1'b0;
		src.pulse();
		chk(wakes, 32'h1);
		repeat (2) wb(1'b0, ICC_OFS_DATA, 32'h0);
	endtask

	task automatic t_rerst();
		setc(ICC_RISE, 2'h0, 1'b0, 1'b0, 1'b0);
		wb(1'b1, ICC_OFS_MASK, 32'h7);
		src.pulse();
		chk(irq_o, 1'b1);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(irq_o, 1'b0);
		rdchk(ICC_OFS_LEVEL, 32'h0);
		rdchk(ICC_OFS_STAT, 32'h0);
		rdchk(ICC_OFS_MASK, 32'h0);
		rdchk(ICC_OFS_CTRL, 32'h0);
	endtask

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_modes();
		t_div(ICC_DIV4, 4);
		t_div(ICC_DIV16, 16);
		t_width();
		t_fifo();
		t_irq();
		t_rerst();
		t_wake();
		tally_and_finish();
	end
endmodule // tb_input_capture_channel
